// File: logic/cpd_decoder.v
// Prebyte-aware instruction decoder and effective-address unit for an 8-bit CPU.
// What this block does
// - Short indirect: byte pointer gives page-zero operand.
// - Long indirect: byte pointer address, word pointer.
// - Indirect indexed adds index to fetched pointer.
// - Short indirect indexed reaches 1FE, one byte.
// - ALU ops accept long and short forms.
// - Read-modify-write, bit, jump ops short only.
// - Relative adds signed 8-bit offset to PC.
// - Relative direct offset follows the opcode.
// - Relative indirect fetches offset via pointer.
// - 63 instructions in 13 groups.
// - Instructions span one to four bytes.
// - Optional prebyte, opcode, zero to two bytes.
// - Three prebytes reinterpret the following opcode.
// - Prebyte 90 swaps X for Y.
// - Prebyte 92 turns direct forms indirect.
// - Prebyte 92 makes X indexed indirect indexed.
// - Prebyte 91 gives Y indirect indexed.
// - Four flag ops, four interrupt ops.
// - Unknown opcode byte raises illegal-opcode reset.
// - Disallowed prebyte combination causes no reset.
`include "cpd_defines.vh"

module cpd_decoder (
   // Clock and reset
   input wire clk,
   input wire arst_n,
   // Program memory
   output reg prog_rd,
   output reg [15:0] prog_addr,
   input wire prog_ack,
   input wire [7:0] prog_rdata,
   // Data memory
   output reg data_rd,
   output reg [15:0] data_addr,
   input wire data_ack,
   input wire [7:0] data_rdata,
   // Core control
   input wire pc_load,
   input wire [15:0] pc_value,
   input wire [7:0] x_reg,
   input wire [7:0] y_reg,
   input wire dec_accept,
   input wire take_branch,
   // Decoded instruction
   output reg dec_valid,
   output reg [7:0] dec_opcode,
   output reg [3:0] dec_group,
   output reg [4:0] dec_mode,
   output reg dec_use_y,
   output reg dec_short_only,
   output reg dec_pre_ignored,
   output reg [2:0] dec_len,
   output reg [15:0] dec_ea,
   output reg [15:0] dec_rel_target,
   output reg [15:0] dec_next_pc,
   output reg illegal_rst
);

   localparam [6:0] S_IDLE = 7'h01;
   localparam [6:0] S_OPC = 7'h02;
   localparam [6:0] S_DEC = 7'h04;
   localparam [6:0] S_ARG = 7'h08;
   localparam [6:0] S_PTR = 7'h10;
   localparam [6:0] S_CALC = 7'h20;
   localparam [6:0] S_WAIT = 7'h40;

   // ==========================================================
   // Group lookups for the two regular opcode families; only the read-modify-write one also gives legality
   function [4:0] rmw_info;
      input [3:0] n;
      begin
         case (n)
            4'h0, 4'h3: rmw_info = {1'b1, `CPD_G_LOGIC};
            4'h4, 4'h6, 4'h7, 4'h8, 4'h9, 4'hE: rmw_info = {1'b1, `CPD_G_SHIFT};
            4'hA, 4'hC: rmw_info = {1'b1, `CPD_G_INCDEC};
            4'hD: rmw_info = {1'b1, `CPD_G_CMP};
            4'hF: rmw_info = {1'b1, `CPD_G_LOAD};
            default: rmw_info = {1'b0, `CPD_G_LOAD};
         endcase
      end
   endfunction

   function [3:0] alu_group;
      input [3:0] n;
      begin
         case (n)
            4'h0, 4'h2, 4'h9, 4'hB: alu_group = `CPD_G_ARITH;
            4'h1, 4'h3, 4'h5: alu_group = `CPD_G_CMP;
            4'h4, 4'h8, 4'hA: alu_group = `CPD_G_LOGIC;
            4'hC, 4'hD: alu_group = `CPD_G_JUMP;
            default: alu_group = `CPD_G_LOAD;
         endcase
      end
   endfunction

   reg [6:0] state;
   reg [15:0] fpc;
   reg [1:0] psel;
   reg [7:0] opc;
   reg [7:0] b1;
   reg [7:0] b2;
   reg [7:0] ph;
   reg [7:0] pl;
   reg [1:0] nb;
   reg [15:0] arg_addr;

   wire [3:0] form = opc[7:4];
   wire [3:0] n = opc[3:0];
   wire [4:0] rmw = rmw_info(n);
   wire is_pre = (prog_rdata == `CPD_PRE_Y) || (prog_rdata == `CPD_PRE_IX) ||
      (prog_rdata == `CPD_PRE_IY);

   // ==========================================================
   // Opcode decode from the captured prebyte and opcode
   reg ok_y;
   reg ok_ix;
   reg ok_iy;
   reg d_legal;
   reg [4:0] d_mode;
   reg [3:0] d_group;
   reg d_use_y;
   reg d_rel;
   reg d_rel_ind;
   reg d_ptr;
   reg d_ptr_word;
   reg [1:0] d_extra;
   reg d_short_only;

   always @* begin
      // A prebyte only acts on the forms it is defined for; elsewhere it is dropped.
      ok_y = (psel == `CPD_PSEL_Y) && (form == `CPD_F_RMW_X || form == `CPD_F_RMW_SIX ||
         form == `CPD_F_RMW_IX0 || form >= `CPD_F_IMM);
      ok_ix = (psel == `CPD_PSEL_IX) && (form <= `CPD_F_RMW_DIR || form == `CPD_F_RMW_SIX ||
         (form >= `CPD_F_SDIR && form <= `CPD_F_SIX) ||
         (form == `CPD_F_MISC && n == `CPD_OP_RELATIVE_SUBROUTINE_CALL));
      ok_iy = (psel == `CPD_PSEL_IY) && (form == `CPD_F_RMW_SIX || form == `CPD_F_LIX ||
         form == `CPD_F_SIX);
      d_legal = 1'b1;
      d_mode = `CPD_M_INH;
      d_group = `CPD_G_LOAD;
      d_use_y = ok_y || ok_iy;
      d_rel = 1'b0;
      d_rel_ind = 1'b0;
      d_ptr = ok_ix || ok_iy;
      d_ptr_word = 1'b0;
      d_extra = 2'd1;
      d_short_only = 1'b1;
      case (form)
         `CPD_F_BTJ: begin
            d_group = `CPD_G_BTJ;
            d_mode = ok_ix ? `CPD_M_BIREL : `CPD_M_BREL;
            d_rel = 1'b1;
            d_extra = 2'd2;
         end
         `CPD_F_BIT: begin
            d_group = `CPD_G_BIT;
            d_mode = ok_ix ? `CPD_M_BIND : `CPD_M_BDIR;
         end
         `CPD_F_JR: begin
            d_group = (n == `CPD_OP_JRA || n == `CPD_OP_JRF) ? `CPD_G_JUMP : `CPD_G_CBR;
            d_mode = ok_ix ? `CPD_M_RIND : `CPD_M_RDIR;
            d_rel = 1'b1;
            d_rel_ind = ok_ix;
         end
         `CPD_F_RMW_DIR, `CPD_F_RMW_A, `CPD_F_RMW_X, `CPD_F_RMW_SIX, `CPD_F_RMW_IX0: begin
            d_legal = rmw[4];
            d_group = rmw[3:0];
            if (form == `CPD_F_RMW_DIR) begin
               d_mode = ok_ix ? `CPD_M_SIND : `CPD_M_SDIR;
            end else if (form == `CPD_F_RMW_SIX) begin
               d_mode = d_ptr ? `CPD_M_SIIX : `CPD_M_SIX;
            end else if (form == `CPD_F_RMW_IX0) begin
               d_mode = `CPD_M_IX0;
               d_extra = 2'd0;
            end else begin
               d_extra = 2'd0;
            end
         end
         `CPD_F_MISC: begin
            d_extra = 2'd0;
            case (n)
               4'h0, 4'h2, 4'h3, 4'h4: d_group = `CPD_G_INT;
               4'h5, 4'h6, 4'h7, 4'h8: d_group = `CPD_G_FLAG;
               4'h9, 4'hC, 4'hD: d_group = `CPD_G_STACK;
               4'hB: d_group = `CPD_G_ARITH;
               default: d_group = `CPD_G_JUMP;
            endcase
            if (n == `CPD_OP_RELATIVE_SUBROUTINE_CALL) begin
               d_mode = ok_ix ? `CPD_M_RIND : `CPD_M_RDIR;
               d_rel = 1'b1;
               d_rel_ind = ok_ix;
               d_extra = 2'd1;
            end
            d_legal = (n != `CPD_OP_MISC_BAD);
         end
         `CPD_F_PRE: begin
            d_legal = 1'b0;
         end
         default: begin
            // Arithmetic, logic, load, compare, jump and call families.
            d_group = alu_group(n);
            d_short_only = (d_group == `CPD_G_JUMP);
            if (form == `CPD_F_IMM) begin
               d_mode = `CPD_M_IMM;
               d_legal = !(n == `CPD_OP_JP || n == `CPD_OP_CALL || n == `CPD_OP_ST || n == `CPD_OP_STX);
            end else if (form == `CPD_F_SDIR) begin
               d_mode = ok_ix ? `CPD_M_SIND : `CPD_M_SDIR;
            end else if (form == `CPD_F_LDIR) begin
               d_mode = ok_ix ? `CPD_M_LIND : `CPD_M_LDIR;
               d_ptr_word = ok_ix;
               d_extra = ok_ix ? 2'd1 : 2'd2;
               d_legal = !d_short_only;
            end else if (form == `CPD_F_LIX) begin
               d_mode = d_ptr ? `CPD_M_LIIX : `CPD_M_LIX;
               d_ptr_word = d_ptr;
               d_extra = d_ptr ? 2'd1 : 2'd2;
               d_legal = !d_short_only;
            end else if (form == `CPD_F_SIX) begin
               d_mode = d_ptr ? `CPD_M_SIIX : `CPD_M_SIX;
            end else begin
               d_mode = `CPD_M_IX0;
               d_extra = 2'd0;
            end
         end
      endcase
   end

   // ==========================================================
   // Effective address and relative target
   reg [7:0] idx;
   reg [7:0] off;
   reg [15:0] ea;
   reg [15:0] target;

   always @* begin
      idx = d_use_y ? y_reg : x_reg;
      off = d_rel_ind ? pl : ((form == `CPD_F_BTJ) ? b2 : b1);
      target = fpc + {{8{off[7]}}, off};
      case (d_mode)
         `CPD_M_IMM: ea = arg_addr;
         `CPD_M_SDIR, `CPD_M_BDIR, `CPD_M_BREL: ea = {8'h00, b1};
         `CPD_M_LDIR: ea = {b1, b2};
         `CPD_M_IX0: ea = {8'h00, idx};
         `CPD_M_SIX: ea = {8'h00, b1} + {8'h00, idx};
         `CPD_M_LIX: ea = {b1, b2} + {8'h00, idx};
         `CPD_M_SIND, `CPD_M_BIND, `CPD_M_BIREL: ea = {8'h00, pl};
         `CPD_M_LIND: ea = {ph, pl};
         `CPD_M_SIIX: ea = {8'h00, pl} + {8'h00, idx};
         `CPD_M_LIIX: ea = {ph, pl} + {8'h00, idx};
         default: ea = 16'h0000;
      endcase
   end

   // ==========================================================
   // Fetch sequencer
   wire [1:0] ptr_cnt = d_ptr_word ? 2'd2 : 2'd1;
   wire need_data = d_ptr || d_rel_ind;

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= S_IDLE;
         fpc <= 16'h0000;
         psel <= `CPD_PSEL_NONE;
         opc <= 8'h00;
         b1 <= 8'h00;
         b2 <= 8'h00;
         ph <= 8'h00;
         pl <= 8'h00;
         nb <= 2'd0;
         arg_addr <= 16'h0000;
         prog_rd <= 1'b0;
         prog_addr <= 16'h0000;
         data_rd <= 1'b0;
         data_addr <= 16'h0000;
         dec_valid <= 1'b0;
         dec_opcode <= 8'h00;
         dec_group <= 4'h0;
         dec_mode <= 5'h00;
         dec_use_y <= 1'b0;
         dec_short_only <= 1'b0;
         dec_pre_ignored <= 1'b0;
         dec_len <= 3'd0;
         dec_ea <= 16'h0000;
         dec_rel_target <= 16'h0000;
         dec_next_pc <= 16'h0000;
         illegal_rst <= 1'b0;
      end else begin
         illegal_rst <= 1'b0;
         if (pc_load) begin
            // A load abandons any instruction in flight.
            state <= S_OPC;
            fpc <= pc_value;
            psel <= `CPD_PSEL_NONE;
            prog_rd <= 1'b0;
            data_rd <= 1'b0;
            dec_valid <= 1'b0;
         end else begin
            case (state)
               S_IDLE: begin
                  state <= S_IDLE;
               end
               S_OPC: begin
                  if (!prog_rd) begin
                     prog_rd <= 1'b1;
                     prog_addr <= fpc;
                  end else if (prog_ack) begin
                     prog_rd <= 1'b0;
                     fpc <= fpc + 16'h0001;
                     if (is_pre) begin
                        // A second prebyte replaces the first.
                        psel <= (prog_rdata == `CPD_PRE_Y) ? `CPD_PSEL_Y :
                           (prog_rdata == `CPD_PRE_IX) ? `CPD_PSEL_IX : `CPD_PSEL_IY;
                     end else begin
                        opc <= prog_rdata;
                        state <= S_DEC;
                     end
                  end
               end
               S_DEC: begin
                  arg_addr <= fpc;
                  nb <= 2'd0;
                  if (!d_legal) begin
                     illegal_rst <= 1'b1;
                     state <= S_IDLE;
                  end else if (d_extra != 2'd0) begin
                     state <= S_ARG;
                  end else begin
                     state <= S_CALC;
                  end
               end
               S_ARG: begin
                  if (!prog_rd) begin
                     prog_rd <= 1'b1;
                     prog_addr <= fpc;
                  end else if (prog_ack) begin
                     prog_rd <= 1'b0;
                     fpc <= fpc + 16'h0001;
                     nb <= nb + 2'd1;
                     if (nb == 2'd0) begin
                        b1 <= prog_rdata;
                     end else begin
                        b2 <= prog_rdata;
                     end
                     if (nb + 2'd1 == d_extra) begin
                        nb <= 2'd0;
                        ph <= 8'h00;
                        state <= need_data ? S_PTR : S_CALC;
                     end
                  end
               end
               S_PTR: begin
                  if (!data_rd) begin
                     data_rd <= 1'b1;
                     // Second pointer byte wraps inside page zero.
                     data_addr <= {8'h00, b1 + {6'h00, nb}};
                  end else if (data_ack) begin
                     data_rd <= 1'b0;
                     nb <= nb + 2'd1;
                     if (nb == 2'd0 && d_ptr_word) begin
                        ph <= data_rdata;
                     end else begin
                        pl <= data_rdata;
                     end
                     if (nb + 2'd1 == ptr_cnt) begin
                        state <= S_CALC;
                     end
                  end
               end
               S_CALC: begin
                  dec_valid <= 1'b1;
                  dec_opcode <= opc;
                  dec_group <= d_group;
                  dec_mode <= d_mode;
                  dec_use_y <= d_use_y;
                  dec_short_only <= d_short_only;
                  dec_pre_ignored <= (psel != `CPD_PSEL_NONE) && !(ok_y || ok_ix || ok_iy);
                  dec_len <= {2'b00, psel != `CPD_PSEL_NONE} + 3'd1 + {1'b0, d_extra};
                  dec_ea <= ea;
                  dec_rel_target <= d_rel ? target : fpc;
                  dec_next_pc <= fpc;
                  state <= S_WAIT;
               end
               S_WAIT: begin
                  if (dec_accept) begin
                     dec_valid <= 1'b0;
                     psel <= `CPD_PSEL_NONE;
                     fpc <= (take_branch && d_rel) ? dec_rel_target : fpc;
                     state <= S_OPC;
                  end
               end
               default: begin
                  state <= S_IDLE;
               end
            endcase
         end
      end
   end

endmodule

// File: logic/cpd_defines.vh
// Constants for the prebyte decoder and effective-address unit.
`ifndef CPD_DEFINES_VH
`define CPD_DEFINES_VH

// ==========================================================
// Prebyte codes
`define CPD_PRE_Y 8'h90
`define CPD_PRE_IY 8'h91
`define CPD_PRE_IX 8'h92
// Internal prebyte selection
`define CPD_PSEL_NONE 2'h0
`define CPD_PSEL_Y 2'h1
`define CPD_PSEL_IX 2'h2
`define CPD_PSEL_IY 2'h3

// ==========================================================
// Opcode forms, taken from the upper nibble of the opcode
`define CPD_F_BTJ 4'h0
`define CPD_F_BIT 4'h1
`define CPD_F_JR 4'h2
`define CPD_F_RMW_DIR 4'h3
`define CPD_F_RMW_A 4'h4
`define CPD_F_RMW_X 4'h5
`define CPD_F_RMW_SIX 4'h6
`define CPD_F_RMW_IX0 4'h7
`define CPD_F_MISC 4'h8
`define CPD_F_PRE 4'h9
`define CPD_F_IMM 4'hA
`define CPD_F_SDIR 4'hB
`define CPD_F_LDIR 4'hC
`define CPD_F_LIX 4'hD
`define CPD_F_SIX 4'hE
`define CPD_F_IX0 4'hF

// Operation nibbles that change decoding
`define CPD_OP_JP 4'hC
`define CPD_OP_CALL 4'hD
`define CPD_OP_ST 4'h7
`define CPD_OP_STX 4'hF
`define CPD_OP_RELATIVE_SUBROUTINE_CALL 4'hE
`define CPD_OP_MISC_BAD 4'hF
`define CPD_OP_JRA 4'h0
`define CPD_OP_JRF 4'h1

// ==========================================================
// Addressing modes (17)
`define CPD_M_INH 5'h00
`define CPD_M_IMM 5'h01
`define CPD_M_SDIR 5'h02
`define CPD_M_LDIR 5'h03
`define CPD_M_IX0 5'h04
`define CPD_M_SIX 5'h05
`define CPD_M_LIX 5'h06
`define CPD_M_SIND 5'h07
`define CPD_M_LIND 5'h08
`define CPD_M_SIIX 5'h09
`define CPD_M_LIIX 5'h0A
`define CPD_M_RDIR 5'h0B
`define CPD_M_RIND 5'h0C
`define CPD_M_BDIR 5'h0D
`define CPD_M_BIND 5'h0E
`define CPD_M_BREL 5'h0F
`define CPD_M_BIREL 5'h10

// ==========================================================
// Instruction groups (13)
`define CPD_G_LOAD 4'h0
`define CPD_G_STACK 4'h1
`define CPD_G_INCDEC 4'h2
`define CPD_G_CMP 4'h3
`define CPD_G_LOGIC 4'h4
`define CPD_G_BIT 4'h5
`define CPD_G_BTJ 4'h6
`define CPD_G_ARITH 4'h7
`define CPD_G_SHIFT 4'h8
`define CPD_G_JUMP 4'h9
`define CPD_G_CBR 4'hA
`define CPD_G_INT 4'hB
`define CPD_G_FLAG 4'hC

`endif

// File: verif/cpd_decoder_props.sv
// Port checker for the prebyte decoder, bound to the design.
`include "cpd_defines.vh"

module cpd_decoder_props (
   // Clock and reset
   input logic clk,
   input logic arst_n,
   // Memory handshakes
   input logic prog_rd,
   input logic [15:0] prog_addr,
   input logic prog_ack,
   input logic data_rd,
   input logic [15:0] data_addr,
   input logic data_ack,
   // Core control
   input logic pc_load,
   input logic [15:0] pc_value,
   input logic dec_accept,
   // Decode results
   input logic dec_valid,
   input logic [4:0] dec_mode,
   input logic [2:0] dec_len,
   input logic [15:0] dec_ea,
   input logic [15:0] dec_rel_target,
   input logic [15:0] dec_next_pc,
   input logic illegal_rst
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================
   // Handshakes
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   // The load edge first clears the sequencer, so the fetch request rises one edge later.
   a_load_fetch: assert property (pc_load ##1 !pc_load |=> prog_rd && prog_addr == $past(pc_value, 2))
      else $error("fetch not started at loaded pc");
   a_prog_hold: assert property (prog_rd && !prog_ack && !pc_load |=> prog_rd && $stable(prog_addr))
      else $error("program request changed before ack");
   a_prog_drop: assert property (prog_rd && prog_ack && !pc_load |=> !prog_rd)
      else $error("program request held after ack");
   a_data_hold: assert property (data_rd && !data_ack && !pc_load |=> data_rd && $stable(data_addr))
      else $error("data request changed before ack");
   a_data_page: assert property (data_rd |-> data_addr[15:8] == 8'h00)
      else $error("pointer read outside page zero");
   // ==========================================
   // Decode results
   a_valid_hold: assert property (dec_valid && !dec_accept && !pc_load |=> dec_valid && $stable(dec_ea))
      else $error("decode result not held");
   a_accept_drop: assert property (dec_valid && dec_accept |=> !dec_valid)
      else $error("valid kept after accept");
   a_len_range: assert property (dec_valid |-> dec_len >= 3'd1 && dec_len <= 3'd4)
      else $error("length out of range");
   a_ill_pulse: assert property (illegal_rst |=> !illegal_rst && !dec_valid)
      else $error("illegal reset not a lone pulse");
   a_short_page: assert property (dec_valid && dec_mode == `CPD_M_SIND |-> dec_ea[15:8] == 8'h00)
      else $error("short indirect beyond page zero");
   a_siix_reach: assert property (dec_valid && dec_mode == `CPD_M_SIIX |-> dec_ea <= 16'h01FE)
      else $error("short indirect indexed beyond 1FE");
   a_rel_span: assert property (dec_valid && dec_mode == `CPD_M_RDIR |->
      16'(dec_rel_target - dec_next_pc + 16'h0080) < 16'h0100)
      else $error("relative target beyond signed byte");
   c_long_ind: cover property (dec_valid && dec_mode == `CPD_M_LIND);
   c_rel_ind: cover property (dec_valid && dec_mode == `CPD_M_RIND);
   c_illegal: cover property (illegal_rst);
endmodule

bind cpd_decoder cpd_decoder_props chk (.clk(clk), .arst_n(arst_n), .prog_rd(prog_rd), .prog_addr(prog_addr),
   .prog_ack(prog_ack), .data_rd(data_rd), .data_addr(data_addr), .data_ack(data_ack), .pc_load(pc_load),
   .pc_value(pc_value), .dec_accept(dec_accept), .dec_valid(dec_valid), .dec_mode(dec_mode), .dec_len(dec_len),
   .dec_ea(dec_ea), .dec_rel_target(dec_rel_target), .dec_next_pc(dec_next_pc), .illegal_rst(illegal_rst));

// File: verif/cpd_decoder_tb.sv
// Self-checking testbench for the prebyte decoder.
`include "cpd_defines.vh"

module cpd_decoder_tb;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {logic ill; logic [46:0] v; logic [46:0] m;} cpd_exp_t;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic pc_load = 1'b0;
   logic [15:0] pc_value = 16'h0000;
   logic [7:0] x_reg = 8'h00;
   logic [7:0] y_reg = 8'h00;
   logic dec_accept = 1'b0;
   logic take_branch = 1'b0;
   wire prog_rd, prog_ack, data_rd, data_ack, dec_valid, dec_use_y, dec_short_only, dec_pre_ignored, illegal_rst;
   wire [15:0] prog_addr, data_addr, dec_ea, dec_rel_target, dec_next_pc;
   wire [7:0] prog_rdata, data_rdata, dec_opcode;
   wire [3:0] dec_group;
   wire [4:0] dec_mode;
   wire [2:0] dec_len;
   cpd_exp_t exp_q[$];
   int err_total = 0;
   int n_checks = 0;
   int cyc = 0;
   logic ill_seen = 1'b0;
   logic vld_d = 1'b0;
   localparam logic [46:0] M_ALL = '1;
   localparam logic [46:0] M_NOG = 47'h7FF_FFFF_FFFF;
   localparam logic [46:0] M_RELX = ~((47'h1 << 33) | (47'hFFFF << 16));
   localparam logic [63:0] ALU_GRP = 64'h0000_7474_0034_0737;

   cpd_decoder uut (.clk(clk), .arst_n(arst_n), .prog_rd(prog_rd), .prog_addr(prog_addr), .prog_ack(prog_ack),
      .prog_rdata(prog_rdata), .data_rd(data_rd), .data_addr(data_addr), .data_ack(data_ack),
      .data_rdata(data_rdata), .pc_load(pc_load), .pc_value(pc_value), .x_reg(x_reg), .y_reg(y_reg),
      .dec_accept(dec_accept), .take_branch(take_branch), .dec_valid(dec_valid), .dec_opcode(dec_opcode),
      .dec_group(dec_group), .dec_mode(dec_mode), .dec_use_y(dec_use_y), .dec_short_only(dec_short_only),
      .dec_pre_ignored(dec_pre_ignored), .dec_len(dec_len), .dec_ea(dec_ea), .dec_rel_target(dec_rel_target),
      .dec_next_pc(dec_next_pc), .illegal_rst(illegal_rst));
   cpd_mem_model mem_i (.clk(clk), .arst_n(arst_n), .prog_rd(prog_rd), .prog_addr(prog_addr),
      .prog_ack(prog_ack), .prog_rdata(prog_rdata), .data_rd(data_rd), .data_addr(data_addr),
      .data_ack(data_ack), .data_rdata(data_rdata));

   initial begin
      forever #10 clk = ~clk;
   end

   // ==========================================
   // Comparison and reporting
   function automatic logic [46:0] mk(input logic [3:0] g, input logic [4:0] md, input logic [2:0] ln,
      input logic [2:0] fl, input logic [15:0] ea, input logic [15:0] tg);
      return {g, md, ln, fl, ea, tg};
   endfunction
   task automatic cmp_dec(input logic [46:0] got, input logic [46:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmp_ill(input logic got, input logic exp);
      cmp_dec({46'h0, got}, {46'h0, exp});
   endtask
   task automatic wrap_up;
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // Watches the outputs and pairs each result with the oldest note.
   always @(posedge clk) begin
      cpd_exp_t e;
      cyc <= cyc + 1;
      vld_d <= dec_valid;
      if (illegal_rst) ill_seen <= 1'b1;
      if ((dec_valid && !vld_d) || illegal_rst) begin
         e = (exp_q.size() > 0) ? exp_q.pop_front() : cpd_exp_t'{1'b1, 47'h0, 47'h0};
         cmp_ill(illegal_rst, e.ill);
         if (!e.ill && !illegal_rst) cmp_dec(e.m & {dec_group, dec_mode, dec_len, dec_use_y, dec_short_only,
            dec_pre_ignored, dec_ea, dec_rel_target}, e.m & e.v);
      end
      if (cyc == 20000) begin
         err_total++;
         wrap_up();
      end
   end

   // ==========================================
   // Stimulus
   task automatic run(input logic [15:0] p, input logic [31:0] code, input int n, input logic [46:0] v,
      input logic [46:0] m, input logic ill);
      int k;
      logic [7:0] op;
      for (k = 0; k < n; k++) mem_i.mem[16'(p + k)] = code[31 - 8 * k -: 8];
      exp_q.push_back('{ill, v, m});
      ill_seen = 1'b0;
      @(posedge clk);
      #1 pc_load = 1'b1;
      pc_value = p;
      @(posedge clk);
      #1 pc_load = 1'b0;
      for (k = 0; k < 80 && !dec_valid && !ill_seen; k++) begin
         @(posedge clk);
         #1;
      end
      if (k == 80) cmp_ill(1'b0, 1'b1);
      if (dec_valid) begin
         op = code[31:24];
         if (op == `CPD_PRE_Y || op == `CPD_PRE_IX || op == `CPD_PRE_IY) op = code[23:16];
         cmp_dec(47'(dec_opcode), 47'(op));
         cmp_dec(47'(dec_next_pc), 47'(p + 16'(n)));
         repeat ($urandom_range(2, 0)) @(posedge clk);
         #1 dec_accept = 1'b1;
         take_branch = 1'($urandom);
         @(posedge clk);
         #1 dec_accept = 1'b0;
      end
   endtask

   initial begin
      logic [7:0] o;
      logic [3:0] g;
      logic [31:0] bad;
      logic [23:0] ptab [10];
      bad = 32'h958F31AC;
      ptab = '{24'h002045, 24'h002112, 24'h002234, 24'h00FFAB, 24'h0000CD,
         24'h0030FF, 24'h003180, 24'h0032F0, 24'h004080, 24'h006077};
      void'($urandom(76));
      repeat (12) @(posedge clk);
      // The pointer table goes in only after the model has filled its memory at time zero.
      for (int i = 0; i < 10; i++) mem_i.mem[ptab[i][23:8]] = ptab[i][7:0];
      #1 arst_n = 1'b1;
      x_reg = 8'hFF;
      y_reg = 8'($urandom);
      run(16'h0400, 32'hB610_0000, 2, mk(`CPD_G_LOAD, `CPD_M_SDIR, 2, 0, 16'h0010, 16'h0402), M_ALL, 0);
      run(16'h0410, 32'h92B6_2000, 3, mk(`CPD_G_LOAD, `CPD_M_SIND, 3, 0, 16'h0045, 16'h0413), M_ALL, 0);
      run(16'h0420, 32'h92C6_2100, 3, mk(`CPD_G_LOAD, `CPD_M_LIND, 3, 0, 16'h1234, 16'h0423), M_ALL, 0);
      run(16'h0430, 32'h92CB_FF00, 3, mk(`CPD_G_ARITH, `CPD_M_LIND, 3, 0, 16'hABCD, 16'h0433), M_ALL, 0);
      run(16'h0440, 32'h92E6_3000, 3, mk(`CPD_G_LOAD, `CPD_M_SIIX, 3, 0, 16'h01FE, 16'h0443), M_ALL, 0);
      run(16'h0450, 32'h91D6_3100, 3, mk(`CPD_G_LOAD, `CPD_M_LIIX, 3, 4, 16'h80F0 + y_reg, 16'h0453), M_ALL, 0);
      run(16'h0460, 32'h90F6_0000, 2, mk(`CPD_G_LOAD, `CPD_M_IX0, 2, 4, {8'h00, y_reg}, 16'h0462), M_ALL, 0);
      run(16'h0470, 32'h91B6_1000, 3, mk(`CPD_G_LOAD, `CPD_M_SDIR, 3, 1, 16'h0010, 16'h0473), M_ALL, 0);
      run(16'h0480, 32'h3C50_0000, 2, mk(0, `CPD_M_SDIR, 2, 2, 16'h0050, 16'h0482), M_NOG, 0);
      run(16'h0500, 32'h20FE_0000, 2, mk(`CPD_G_JUMP, `CPD_M_RDIR, 2, 0, 0, 16'h0500), M_RELX, 0);
      o = 8'($urandom);
      run(16'h0600, {8'h27, o, 16'h0}, 2, mk(`CPD_G_CBR, `CPD_M_RDIR, 2, 0, 0, 16'h0602 + {{8{o[7]}}, o}), M_RELX, 0);
      run(16'h0700, 32'h9227_4000, 3, mk(`CPD_G_CBR, `CPD_M_RIND, 3, 0, 0, 16'h0683), M_RELX, 0);
      run(16'h0800, 32'h9203_6005, 4, mk(`CPD_G_BTJ, `CPD_M_BIREL, 4, 0, 16'h0077, 16'h0809), ~(47'h1 << 33), 0);
      for (int i = 0; i < 12; i++) begin
         if (i != 3 && i != 7) run(16'h0900 + 16'(16 * i), {4'hC, 4'(i), 24'h1234_00}, 3,
            mk(ALU_GRP[i * 4 +: 4], `CPD_M_LDIR, 3, 0, 16'h1234, 16'h0903 + 16'(16 * i)), M_ALL, 0);
      end
      for (int i = 0; i < 9; i++) begin
         g = (i == 1) ? `CPD_G_JUMP : (i < 5) ? `CPD_G_INT : `CPD_G_FLAG;
         run(16'h0A00 + 16'(4 * i), {8'h80 + 8'(i), 24'h0}, 1,
            mk(g, `CPD_M_INH, 1, 0, 0, 16'h0A01 + 16'(4 * i)), M_RELX, 0);
      end
      for (int i = 0; i < 4; i++) run(16'h0B00 + 16'(4 * i), {bad[31 - 8 * i -: 8], 24'h0}, 1, 0, 0, 1);
      repeat (10) @(posedge clk);
      if (exp_q.size() != 0) cmp_ill(1'b0, 1'b1);
      wrap_up();
   end
endmodule

// File: verif/cpd_mem_model.sv
// Behavioural program and data memory answering the decoder's reads.
module cpd_mem_model (
   // Clock and reset
   input wire clk,
   input wire arst_n,
   // Program port
   input wire prog_rd,
   input wire [15:0] prog_addr,
   output wire prog_ack,
   output wire [7:0] prog_rdata,
   // Data port
   input wire data_rd,
   input wire [15:0] data_addr,
   output wire data_ack,
   output wire [7:0] data_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [0:65535];
   logic [1:0] pw;
   logic [1:0] dw;
   logic [7:0] pat;
   // The byte is read at the live address, so a fetch redirected by a load is never answered with stale data.
   assign prog_ack = prog_rd && pw == 2'h0;
   assign data_ack = data_rd && dw == 2'h0;
   // Outside an answer the lines carry a moving pattern, never the last byte.
   assign prog_rdata = prog_ack ? mem[prog_addr] : pat;
   assign data_rdata = data_ack ? mem[data_addr] : ~pat;
   initial begin
      for (int a = 0; a < 65536; a++) mem[a] = 8'h8A;
   end
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pw <= 2'h1;
         dw <= 2'h1;
         pat <= 8'h5A;
      end else begin
         pat <= pat + 8'h3B;
         pw <= (!prog_rd || prog_ack) ? 2'($urandom_range(2, 0)) : pw - 2'h1;
         dw <= (!data_rd || data_ack) ? 2'($urandom_range(2, 0)) : dw - 2'h1;
      end
   end
endmodule
